//--- src/usb_dev_regs.vh
// register offsets, field positions, reset values and timing of the usb device port
`ifndef USB_DEV_REGS_VH
`define USB_DEV_REGS_VH

// ****************************************
// timing
// ****************************************
`define CLK_KHZ 25000
`define SUSP_WAIT_MS 5
`define RESUME_K_MS 2

// ****************************************
// global register offsets
// ****************************************
`define OFS_CTRL 12'h000
`define OFS_IEN 12'h010
`define OFS_INTSTA 12'h014
`define OFS_CLRINT 12'h018
`define OFS_TST 12'h0e0
`define OFS_EP0_CTLENB 12'h104
`define OFS_EP0_CTLDIS 12'h108
`define OFS_EP0_CTL 12'h10c

// ****************************************
// data endpoint register offsets
// ****************************************
`define OFS_EPCFG 12'h120
`define OFS_EPCTLENB 12'h124
`define OFS_EPCTLDIS 12'h128
`define OFS_EPCTL 12'h12c
`define OFS_EPSETSTA 12'h134
`define OFS_EPCLRSTA 12'h138
`define OFS_EPSTA 12'h13c
`define OFS_EPDATA 12'h140

// ****************************************
// field positions
// ****************************************
`define CTRL_ADDR_VALID 7
`define CTRL_ENABLE 8
`define CTRL_DETACH 9
`define CTRL_REWAKEUP 10
`define INT_SPEED 0
`define INT_SUSPEND 1
`define INT_RESET_DONE 3
`define INT_WAKE 4
`define INT_UP_RESUME 5
`define INT_EP0 8
`define INT_EP1 9
`define STA_FORCE_HALT 31
`define CLR_TOGGLE 0
// event flag index, status bits [15:4] and mask bits [15:4]
`define EV_SHORT 0
`define EV_BUSY 1
`define EV_CRC_STALL 4
`define EV_FLOW 5
`define EV_RXRDY 8
`define EV_OVFLW 9
`define EV_MDATA 10
`define EV_DATAX 11

// ****************************************
// reset values and codes
// ****************************************
`define CTRL_RST 32'h0000_0200
`define IEN_RST 32'h0000_0010
`define TYPE_ISO 2'h1
`define PID_DATA0 2'h0
`define PID_DATA1 2'h1
`define PID_DATA2 2'h2
`define PID_MDATA 2'h3

`endif

//--- src/bank_ram.v
// byte-wide bank memory, registered read data
`timescale 1ns/1ps
module bank_ram #(
  parameter AW = 12
) (
  // clock
  input wire clk_sys,
  // write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  // read port
  input wire [AW-1:0] rd_addr,
  output reg [7:0] rd_data
);

  reg [7:0] mem [0:(1<<AW)-1];

  // write and registered read
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // bank_ram

//--- src/usb_dev_port.v
// usb high-speed device port: endpoint banks, halt, speed, suspend, wake and test modes
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "usb_dev_regs.vh"

module usb_dev_port #(
  parameter BYTE_AW = 10,
  parameter SUSP_WAIT_CYC = `SUSP_WAIT_MS * `CLK_KHZ,
  parameter RESUME_K_CYC = `RESUME_K_MS * `CLK_KHZ,
  parameter EP_NUM = 4'h1
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // register port
  input wire [11:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // link events from the packet engine
  input wire sof,
  input wire rx_token_out,
  input wire rx_token_in,
  input wire rx_token_ping,
  input wire [3:0] rx_ep,
  input wire rx_byte_valid,
  input wire [7:0] rx_byte,
  input wire rx_pkt_end,
  input wire [1:0] rx_pid,
  input wire rx_crc_err,
  input wire rx_ipg_timeout,
  // bus state events
  input wire bus_reset,
  input wire bus_reset_end,
  input wire hs_detected,
  input wire bus_idle,
  input wire bus_activity,
  input wire resume_detect,
  // link controls
  output reg tx_stall,
  output reg pullup_en,
  output reg xcvr_en,
  output reg drive_k,
  output reg [2:0] test_sel,
  output reg [6:0] function_address,
  output reg address_valid,
  output reg irq
);

  localparam ST_IDLE = 2'd0;
  localparam ST_RECV = 2'd1;
  localparam ST_DROP = 2'd2;
  // reset words, sliced into the fields below
  localparam [31:0] CTRL_RST_V = `CTRL_RST;
  localparam [31:0] IEN_RST_V = `IEN_RST;

  // ****************************************
  // state
  // ****************************************
  reg controller_enable, detach, rewakeup, activity_seen, suspended, dflt_seen;
  reg speed_hs, suspend_detected, bus_reset_done, wake_up, up_resume_done;
  reg [9:0] ien;
  reg [2:0] tst;
  reg ep0_enable, endpoint_enable, force_halt;
  reg [2:0] max_packet_size;
  reg endpoint_direction;
  reg [1:0] transfer_type, bank_count, transactions_per_microframe;
  reg [11:0] ep_mask, ep_flags;
  reg [1:0] state, wr_bank, current_bank_index, occupied_bank_count, pkt_idx;
  reg [10:0] cnt;
  reg ovf_pend, stall_pend;
  reg [BYTE_AW-1:0] rd_off;
  reg [1:0] pid_arr [0:3];
  reg [10:0] len_arr [0:3];
  reg [19:0] susp_cnt, k_cnt;
  wire [7:0] ram_q;

  // ****************************************
  // decode
  // ****************************************
  wire wr_ctrl = wr && addr == `OFS_CTRL;
  wire wr_clrint = wr && addr == `OFS_CLRINT;
  wire wr_setsta = wr && addr == `OFS_EPSETSTA;
  wire wr_clrsta = wr && addr == `OFS_EPCLRSTA;
  wire rd_data = rd && addr == `OFS_EPDATA;
  wire is_iso = transfer_type == `TYPE_ISO;
  wire high_bw = transactions_per_microframe > 2'd1;
  wire [1:0] nbanks = (bank_count == 2'd0) ? 2'd1 : bank_count;
  wire full = occupied_bank_count >= nbanks;
  wire [10:0] max_bytes = 11'd8 << max_packet_size;
  wire halt_eff = force_halt && !is_iso;
  wire ep_hit = endpoint_enable && rx_ep == EP_NUM;
  wire commit = (state == ST_RECV) && rx_pkt_end && (is_iso || !rx_crc_err) && !stall_pend;
  wire bank_free = wr_clrsta && wdata[`EV_RXRDY+4] && occupied_bank_count != 2'd0;
  wire [1:0] next_wr_bank = (wr_bank + 2'd1 >= nbanks) ? 2'd0 : wr_bank + 2'd1;
  wire [1:0] next_cur_bank = (current_bank_index + 2'd1 >= nbanks) ? 2'd0 :
    current_bank_index + 2'd1;
  wire [1:0] next_occ = occupied_bank_count + {1'b0, commit} - {1'b0, bank_free};

  // expected pid for the packet position inside the microframe
  reg pid_ok;
  always @* begin
    pid_ok = 1'b0;
    if (!high_bw) begin
      pid_ok = pkt_idx == 2'd0 && rx_pid == `PID_DATA0;
    end else if (pkt_idx < transactions_per_microframe) begin
      case (pkt_idx)
        2'd0: pid_ok = rx_pid == `PID_MDATA;
        2'd1: pid_ok = rx_pid == `PID_DATA1;
        2'd2: pid_ok = rx_pid == `PID_DATA2;
        default: pid_ok = 1'b0;
      endcase
    end
  end

  // ****************************************
  // bank memory
  // ****************************************
  wire ram_we = (state == ST_RECV) && rx_byte_valid && cnt < max_bytes && !stall_pend;
  wire [BYTE_AW-1:0] next_rd_off = bank_free ? {BYTE_AW{1'b0}} :
    (rd_data ? rd_off + 1'b1 : rd_off);
  wire [1:0] rd_bank = bank_free ? next_cur_bank : current_bank_index;

  bank_ram #(.AW(BYTE_AW + 2)) u_ram (
    .clk_sys(clk_sys),
    .wr_en(ram_we),
    .wr_addr({wr_bank, cnt[BYTE_AW-1:0]}),
    .wr_data(rx_byte),
    .rd_addr({rd_bank, next_rd_off}),
    .rd_data(ram_q)
  );

  // ****************************************
  // out packet reception
  // ****************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= 11'd0;
      ovf_pend <= 1'b0;
      stall_pend <= 1'b0;
      wr_bank <= 2'd0;
      pkt_idx <= 2'd0;
    end else if (bus_reset) begin
      state <= ST_IDLE;
      wr_bank <= 2'd0;
      pkt_idx <= 2'd0;
    end else begin
      if (sof) begin
        pkt_idx <= 2'd0;
      end
      case (state)
        ST_IDLE: begin
          cnt <= 11'd0;
          ovf_pend <= 1'b0;
          stall_pend <= 1'b0;
          if (rx_token_out && ep_hit) begin
            stall_pend <= halt_eff;
            state <= (is_iso && full) ? ST_DROP : ST_RECV;
          end
        end
        ST_RECV: begin
          if (rx_ipg_timeout) begin
            state <= ST_IDLE;
          end else if (rx_pkt_end) begin
            state <= ST_IDLE;
            if (commit) begin
              wr_bank <= next_wr_bank;
            end
            if (is_iso && !sof && pkt_idx != 2'd3) begin
              pkt_idx <= pkt_idx + 2'd1;
            end
          end else if (rx_byte_valid) begin
            if (cnt < max_bytes) begin
              cnt <= cnt + 11'd1;
            end else begin
              ovf_pend <= 1'b1;
            end
          end
        end
        ST_DROP: begin
          if (rx_ipg_timeout || rx_pkt_end) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // endpoint bank bookkeeping and flags
  // ****************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ep_flags <= 12'h000;
      current_bank_index <= 2'd0;
      occupied_bank_count <= 2'd0;
      rd_off <= {BYTE_AW{1'b0}};
      force_halt <= 1'b0;
      tx_stall <= 1'b0;
      pid_arr[0] <= 2'd0;
      pid_arr[1] <= 2'd0;
      pid_arr[2] <= 2'd0;
      pid_arr[3] <= 2'd0;
      len_arr[0] <= 11'd0;
      len_arr[1] <= 11'd0;
      len_arr[2] <= 11'd0;
      len_arr[3] <= 11'd0;
    end else if (bus_reset) begin
      ep_flags <= 12'h000;
      current_bank_index <= 2'd0;
      occupied_bank_count <= 2'd0;
      rd_off <= {BYTE_AW{1'b0}};
      force_halt <= 1'b0;
      tx_stall <= 1'b0;
    end else begin
      tx_stall <= 1'b0;
      // software clears first, hardware sets below win
      if (wr_clrsta) begin
        ep_flags <= ep_flags & ~wdata[15:4];
        if (wdata[`STA_FORCE_HALT]) begin
          force_halt <= 1'b0;
        end
      end
      if (wr_setsta && wdata[`STA_FORCE_HALT]) begin
        force_halt <= 1'b1;
      end
      rd_off <= next_rd_off;
      occupied_bank_count <= next_occ;
      if (bank_free) begin
        current_bank_index <= next_cur_bank;
        ep_flags[`EV_RXRDY] <= occupied_bank_count > 2'd1;
      end
      // halt answer to in or ping tokens
      if ((rx_token_in || rx_token_ping) && ep_hit && halt_eff) begin
        tx_stall <= 1'b1;
        ep_flags[`EV_CRC_STALL] <= 1'b1;
      end
      if (state == ST_RECV && rx_pkt_end && stall_pend) begin
        tx_stall <= 1'b1;
        ep_flags[`EV_CRC_STALL] <= 1'b1;
      end
      if (state == ST_DROP && rx_pkt_end) begin
        ep_flags[`EV_FLOW] <= 1'b1;
      end
      if (commit) begin
        pid_arr[wr_bank] <= rx_pid;
        len_arr[wr_bank] <= cnt;
        ep_flags[`EV_RXRDY] <= 1'b1;
        if (ovf_pend) begin
          ep_flags[`EV_OVFLW] <= 1'b1;
        end
        if (cnt < max_bytes) begin
          ep_flags[`EV_SHORT] <= 1'b1;
        end
        if (next_occ >= nbanks) begin
          ep_flags[`EV_BUSY] <= 1'b1;
        end
        if (is_iso && (rx_crc_err || !pid_ok)) begin
          ep_flags[`EV_CRC_STALL] <= 1'b1;
        end
        if (rx_pid == `PID_MDATA) begin
          ep_flags[`EV_MDATA] <= 1'b1;
        end else begin
          ep_flags[`EV_DATAX] <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // global control, suspend and remote wake
  // ****************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      function_address <= CTRL_RST_V[6:0];
      address_valid <= CTRL_RST_V[`CTRL_ADDR_VALID];
      controller_enable <= CTRL_RST_V[`CTRL_ENABLE];
      detach <= CTRL_RST_V[`CTRL_DETACH];
      rewakeup <= 1'b0;
      ien <= IEN_RST_V[9:0];
      tst <= 3'd0;
      activity_seen <= 1'b0;
      suspended <= 1'b0;
      dflt_seen <= 1'b0;
      speed_hs <= 1'b0;
      suspend_detected <= 1'b0;
      bus_reset_done <= 1'b0;
      wake_up <= 1'b0;
      up_resume_done <= 1'b0;
      susp_cnt <= 20'd0;
      k_cnt <= 20'd0;
      drive_k <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        function_address <= wdata[6:0];
        address_valid <= wdata[`CTRL_ADDR_VALID];
        controller_enable <= wdata[`CTRL_ENABLE];
        detach <= wdata[`CTRL_DETACH];
        rewakeup <= wdata[`CTRL_REWAKEUP];
      end
      if (wr && addr == `OFS_IEN) begin
        ien <= wdata[9:0];
      end
      if (wr && addr == `OFS_TST) begin
        tst <= wdata[2:0];
      end
      if (wr_clrint) begin
        suspend_detected <= suspend_detected & ~wdata[`INT_SUSPEND];
        bus_reset_done <= bus_reset_done & ~wdata[`INT_RESET_DONE];
        wake_up <= wake_up & ~wdata[`INT_WAKE];
        up_resume_done <= up_resume_done & ~wdata[`INT_UP_RESUME];
      end
      if (bus_activity) begin
        activity_seen <= 1'b1;
      end
      if (detach) begin
        activity_seen <= 1'b0;
      end
      if (bus_reset) begin
        function_address <= 7'd0;
        address_valid <= 1'b0;
        ien <= IEN_RST_V[9:0];
        suspended <= 1'b0;
        dflt_seen <= 1'b0;
      end
      if (bus_reset_end) begin
        speed_hs <= hs_detected;
        bus_reset_done <= 1'b1;
        dflt_seen <= 1'b1;
      end
      if (bus_idle && !suspended) begin
        suspended <= 1'b1;
        suspend_detected <= 1'b1;
      end
      if (suspended && resume_detect) begin
        suspended <= 1'b0;
        wake_up <= 1'b1;
      end
      // time spent in suspend, saturating
      if (!suspended) begin
        susp_cnt <= 20'd0;
      end else if ({12'd0, susp_cnt} < SUSP_WAIT_CYC) begin
        susp_cnt <= susp_cnt + 20'd1;
      end
      // upstream resume: k state after the suspend wait
      if (drive_k) begin
        k_cnt <= k_cnt + 20'd1;
        if ({12'd0, k_cnt} >= RESUME_K_CYC - 1) begin
          drive_k <= 1'b0;
          rewakeup <= 1'b0;
          suspended <= 1'b0;
          up_resume_done <= 1'b1;
        end
      end else if (rewakeup && suspended && {12'd0, susp_cnt} >= SUSP_WAIT_CYC) begin
        drive_k <= 1'b1;
        k_cnt <= 20'd0;
      end
    end
  end

  // ****************************************
  // endpoint configuration
  // ****************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ep0_enable <= 1'b1;
      endpoint_enable <= 1'b0;
      ep_mask <= 12'h000;
      max_packet_size <= 3'd0;
      endpoint_direction <= 1'b0;
      transfer_type <= 2'd0;
      bank_count <= 2'd0;
      transactions_per_microframe <= 2'd0;
    end else if (bus_reset) begin
      ep0_enable <= 1'b0;
      endpoint_enable <= 1'b0;
      ep_mask <= 12'h000;
    end else begin
      if (wr && addr == `OFS_EPCFG) begin
        max_packet_size <= wdata[2:0];
        endpoint_direction <= wdata[3];
        transfer_type <= wdata[5:4];
        bank_count <= wdata[7:6];
        transactions_per_microframe <= wdata[9:8];
      end
      if (wr && addr == `OFS_EP0_CTLENB && wdata[0]) begin
        ep0_enable <= 1'b1;
      end
      if (wr && addr == `OFS_EP0_CTLDIS && wdata[0]) begin
        ep0_enable <= 1'b0;
      end
      if (wr && addr == `OFS_EPCTLENB) begin
        endpoint_enable <= endpoint_enable | wdata[0];
        ep_mask <= ep_mask | wdata[15:4];
      end
      if (wr && addr == `OFS_EPCTLDIS) begin
        endpoint_enable <= endpoint_enable & ~wdata[0];
        ep_mask <= ep_mask & ~wdata[15:4];
      end
    end
  end

  // ****************************************
  // register read mux
  // ****************************************
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0000_0000;
    case (addr)
      `OFS_CTRL: next_rdata = {21'd0, rewakeup, detach, controller_enable,
        address_valid, function_address};
      `OFS_IEN: next_rdata = {22'd0, ien};
      `OFS_INTSTA: next_rdata = {22'd0, 2'b00, 2'b00, up_resume_done, wake_up,
        bus_reset_done, 1'b0, suspend_detected, speed_hs};
      `OFS_TST: next_rdata = {29'd0, tst};
      `OFS_EP0_CTL: next_rdata = {31'd0, ep0_enable};
      `OFS_EPCFG: next_rdata = {22'd0, transactions_per_microframe, bank_count,
        transfer_type, endpoint_direction, max_packet_size};
      `OFS_EPCTL: next_rdata = {16'd0, ep_mask, 3'd0, endpoint_enable};
      `OFS_EPSTA: next_rdata = {force_halt, 2'b00, len_arr[current_bank_index],
        occupied_bank_count, ep_flags, current_bank_index,
        pid_arr[current_bank_index]};
      `OFS_EPDATA: next_rdata = {24'd0, ram_q};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
      pullup_en <= 1'b0;
      xcvr_en <= 1'b0;
      test_sel <= 3'd0;
      irq <= 1'b0;
    end else begin
      rdata <= rd ? next_rdata : 32'h0000_0000;
      pullup_en <= !detach;
      xcvr_en <= controller_enable && !detach && activity_seen && !suspended;
      test_sel <= (speed_hs && dflt_seen) ? tst : 3'd0;
      irq <= (ien[`INT_SUSPEND] && suspend_detected) ||
        (ien[`INT_RESET_DONE] && bus_reset_done) ||
        (ien[`INT_WAKE] && wake_up) ||
        (ien[`INT_UP_RESUME] && up_resume_done) ||
        (ien[`INT_EP1] && |(ep_flags & ep_mask));
    end
  end

endmodule // usb_dev_port

//--- verif/usb_host_model.sv
// host-side link event source for the usb device port
`timescale 1ns/1ps
module usb_host_model (
  // clock
  input wire clk_sys,
  // tokens and packet events
  output logic sof,
  output logic rx_token_out,
  output logic rx_token_in,
  output logic rx_token_ping,
  output logic [3:0] rx_ep,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_pkt_end,
  output logic [1:0] rx_pid,
  output logic rx_crc_err,
  output logic rx_ipg_timeout
);
  // ********
  // idle state, endpoint one addressed
  // ********
  initial begin
    {sof, rx_token_out, rx_token_in, rx_token_ping, rx_ep} = 8'h01;
    {rx_byte_valid, rx_byte, rx_pkt_end, rx_pid, rx_crc_err, rx_ipg_timeout} = 14'h0;
  end
  // one-cycle pulse: bits are sof, out, in, ping
  task tok(input logic [3:0] k);
    @(posedge clk_sys);
    {sof, rx_token_out, rx_token_in, rx_token_ping} <= k;
    @(posedge clk_sys);
    {sof, rx_token_out, rx_token_in, rx_token_ping} <= 4'h0;
  endtask
  // out token, bytes, then end marker or a late data timeout
  task pkt(input int nb, input logic [1:0] pid, input logic crc, input logic late);
    tok(4'h4);
    for (int i = 0; i < nb; i++) begin
      @(posedge clk_sys);
      rx_byte_valid <= 1'b1;
      rx_byte <= 8'(8'h10 + i);
    end
    @(posedge clk_sys);
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    {rx_pkt_end, rx_ipg_timeout, rx_pid, rx_crc_err} <= {!late, late, pid, crc};
    @(posedge clk_sys);
    {rx_pkt_end, rx_ipg_timeout, rx_pid, rx_crc_err} <= {2'h0, ~pid, 1'b0};
  endtask
endmodule // usb_host_model

//--- verif/usb_dev_port_props.sv
// assertions on the usb device port pins
`timescale 1ns/1ps
`include "usb_dev_regs.vh"
module usb_dev_port_props #(
  parameter SUSP_WAIT_CYC = 20,
  parameter RESUME_K_CYC = 8
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // register writes
  input wire [11:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  // link and bus events
  input wire rx_token_in,
  input wire rx_token_ping,
  input wire rx_pkt_end,
  input wire bus_reset,
  input wire bus_idle,
  // link controls
  input wire tx_stall,
  input wire pullup_en,
  input wire xcvr_en,
  input wire drive_k,
  input wire [6:0] function_address,
  input wire address_valid
);
  // ********
  // helpers
  // ********
  int susp_cnt;
  int k_cnt;
  wire ctrl_wr = wr && addr == `OFS_CTRL;
  // cycles since suspend began, and length of the k state
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      susp_cnt <= 0;
      k_cnt <= 0;
    end else begin
      susp_cnt <= bus_idle ? 0 : susp_cnt + 1;
      k_cnt <= drive_k ? k_cnt + 1 : 0;
    end
  end
  // ********
  // properties
  // ********
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_pullup_detach: assert property (
    ctrl_wr ##1 !ctrl_wr |=> pullup_en == !$past(wdata[`CTRL_DETACH], 2))
    else $error("pull-up does not follow detach");
  a_xcvr_detach: assert property (
    ctrl_wr && wdata[`CTRL_DETACH] ##1 !ctrl_wr |=> !xcvr_en)
    else $error("transceiver on while detached");
  a_addr_write: assert property (
    ctrl_wr && !bus_reset ##1 !ctrl_wr && !bus_reset |=>
    {address_valid, function_address} == $past(wdata[7:0], 2))
    else $error("address not taken from control write");
  a_reset_addr: assert property (
    bus_reset |-> ##[1:2] !address_valid && function_address == 7'h0)
    else $error("bus reset kept the address");
  a_stall_cause: assert property (
    tx_stall |-> $past(rx_token_in || rx_token_ping || rx_pkt_end))
    else $error("halt handshake without a token");
  a_stall_pulse: assert property (tx_stall |=> !tx_stall)
    else $error("halt handshake longer than one cycle");
  a_wake_wait: assert property ($rose(drive_k) |-> susp_cnt >= SUSP_WAIT_CYC - 1)
    else $error("k state before the suspend wait");
  a_wake_len: assert property (
    $fell(drive_k) |-> k_cnt >= RESUME_K_CYC - 1 && k_cnt <= RESUME_K_CYC + 1)
    else $error("k state length out of range");
  c_stall: cover property (tx_stall);
  c_wake: cover property ($fell(drive_k));
  c_reset: cover property ($fell(address_valid));
endmodule // usb_dev_port_props

bind usb_dev_port usb_dev_port_props #(
  .SUSP_WAIT_CYC(SUSP_WAIT_CYC),
  .RESUME_K_CYC(RESUME_K_CYC)
) props (.*);

//--- verif/tb_top.sv
// self-checking bench for the usb device port
`timescale 1ns/1ps
`include "usb_dev_regs.vh"
module tb_top;
  // ********
  // signals and instances
  // ********
  logic clk_sys, rst_n, wr, rd, hs_detected;
  logic [4:0] bev;
  logic [11:0] addr;
  logic [31:0] wdata, v;
  int num_errors, checks;
  wire bus_reset = bev[0];
  wire bus_reset_end = bev[1];
  wire bus_idle = bev[2];
  wire bus_activity = bev[3];
  wire resume_detect = bev[4];
  wire sof, rx_token_out, rx_token_in, rx_token_ping, rx_byte_valid, rx_pkt_end;
  wire rx_crc_err, rx_ipg_timeout, tx_stall, pullup_en, xcvr_en, drive_k, address_valid, irq;
  wire [1:0] rx_pid;
  wire [2:0] test_sel;
  wire [3:0] rx_ep;
  wire [6:0] function_address;
  wire [7:0] rx_byte;
  wire [31:0] rdata;
  typedef struct {logic [31:0] cfg; int nb; logic [1:0] pid; logic crc; logic [31:0] msk, exp;}
    row_t;
  // iso out packets: config, length, pid, crc, status mask, expected status
  row_t rows [6] = '{
    '{32'h0000_0110, 4, 2'h0, 1'b0, 32'h1fff_3103, 32'h0011_1000},
    '{32'h0000_0110, 3, 2'h0, 1'b1, 32'h1fff_2103, 32'h000d_0100},
    '{32'h0000_0110, 0, 2'h0, 1'b0, 32'h1fff_3103, 32'h0001_1000},
    '{32'h0000_0110, 10, 2'h0, 1'b0, 32'h1fff_3103, 32'h0021_3000},
    '{32'h0000_0110, 2, 2'h1, 1'b0, 32'h0000_0100, 32'h0000_0100},
    '{32'h0000_0210, 1, 2'h3, 1'b0, 32'h1fff_3103, 32'h0005_1003}};
  usb_dev_port #(.SUSP_WAIT_CYC(20), .RESUME_K_CYC(8)) dut (.*);
  usb_host_model host (.*);
  // ********
  // tasks
  // ********
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task rreg(input logic [11:0] a);
    @(posedge clk_sys);
    {rd, addr} <= {1'b1, a};
    @(posedge clk_sys);
    rd <= 1'b0;
    @(posedge clk_sys);
    v = rdata;
  endtask
  task ev(input logic [4:0] m);
    @(posedge clk_sys);
    bev <= m;
    @(posedge clk_sys);
    bev <= 5'h0;
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ********
  // clock, watchdog and tests
  // ********
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // whole run is a few hundred cycles; allow twenty thousand
  initial begin
    #800000;
    num_errors++;
    end_sim;
  end
  initial begin
    {rst_n, wr, rd, hs_detected, bev, addr, wdata, num_errors, checks} = 0;
    idle(5);
    rst_n <= 1'b1;
    rreg(`OFS_IEN);
    chk(v, 32'h0000_0010);
    wreg(`OFS_CTRL, 32'h0000_0100);
    idle(2);
    chk({pullup_en, xcvr_en}, 32'h0000_0002);
    ev(5'h08);
    idle(2);
    chk(xcvr_en, 32'h1);
    $display("test attach done");
    wreg(`OFS_IEN, 32'h0000_0200);
    wreg(`OFS_CTRL, 32'h0000_01a5);
    hs_detected <= 1'b1;
    ev(5'h01);
    ev(5'h02);
    rreg(`OFS_INTSTA);
    chk(v & 32'h0000_0009, 32'h0000_0009);
    rreg(`OFS_IEN);
    chk(v, 32'h0000_0010);
    rreg(`OFS_CTRL);
    chk(v & 32'h0000_00ff, 32'h0);
    rreg(`OFS_EP0_CTL);
    chk(v, 32'h0);
    for (int t = 1; t < 5; t++) begin
      wreg(`OFS_TST, 32'(t));
      idle(2);
      chk(test_sel, 32'(t));
    end
    $display("test bus reset done");
    wreg(`OFS_IEN, 32'h0000_0200);
    wreg(`OFS_EPCFG, 32'h0000_0110);
    wreg(`OFS_EPCTLENB, 32'h0000_1001);
    foreach (rows[i]) begin
      wreg(`OFS_EPCFG, rows[i].cfg);
      host.tok(4'h8);
      host.pkt(rows[i].nb, rows[i].pid, rows[i].crc, 1'b0);
      rreg(`OFS_EPSTA);
      chk(v & rows[i].msk, rows[i].exp);
      wreg(`OFS_EPCLRSTA, 32'h0000_fff0);
    end
    $display("test iso rows done");
    wreg(`OFS_EPCFG, 32'h0000_0110);
    host.pkt(2, 2'h0, 1'b0, 1'b0);
    idle(2);
    chk(irq, 32'h1);
    wreg(`OFS_EPCTLDIS, 32'h0000_1000);
    idle(2);
    chk(irq, 32'h0);
    host.pkt(2, 2'h0, 1'b0, 1'b0);
    rreg(`OFS_EPSTA);
    chk(v & 32'h0003_0200, 32'h0001_0200);
    wreg(`OFS_EPCLRSTA, 32'h0000_fff0);
    host.pkt(0, 2'h0, 1'b0, 1'b1);
    rreg(`OFS_EPSTA);
    chk(v & 32'h0003_1000, 32'h0);
    $display("test full and late done");
    wreg(`OFS_EPSETSTA, 32'h8000_0000);
    host.tok(4'h2);
    idle(1);
    chk(tx_stall, 32'h0);
    wreg(`OFS_EPCFG, 32'h0000_0120);
    wreg(`OFS_EPSETSTA, 32'h8000_0000);
    for (int k = 0; k < 3; k++) begin
      if (k == 2)
        host.pkt(1, 2'h0, 1'b0, 1'b0);
      else
        host.tok(k ? 4'h1 : 4'h2);
      idle(1);
      chk(tx_stall, 32'h1);
    end
    rreg(`OFS_EPSTA);
    chk(v & 32'h8000_0100, 32'h8000_0100);
    wreg(`OFS_EPCLRSTA, 32'h8000_0001);
    rreg(`OFS_EPSTA);
    chk(v & 32'h8000_0000, 32'h0);
    $display("test halt done");
    ev(5'h04);
    rreg(`OFS_INTSTA);
    chk(v & 32'h0000_0002, 32'h0000_0002);
    wreg(`OFS_CTRL, 32'h0000_0500);
    for (int k = 0; k < 60 && drive_k !== 1'b1; k++) @(posedge clk_sys);
    chk(drive_k, 32'h1);
    rreg(`OFS_INTSTA);
    chk(v & 32'h0000_0002, 32'h0000_0002);
    wreg(`OFS_CLRINT, 32'h0000_0002);
    rreg(`OFS_INTSTA);
    chk(v & 32'h0000_0002, 32'h0);
    // upstream resume ended suspend: idle again before the host resumes
    ev(5'h04);
    ev(5'h10);
    rreg(`OFS_INTSTA);
    chk(v & 32'h0000_0030, 32'h0000_0030);
    idle(20);
    wreg(`OFS_CTRL, 32'h0000_0200);
    idle(2);
    chk({pullup_en, xcvr_en}, 32'h0);
    $display("test suspend and detach done");
    // full-speed reset: reset done again, speed bit low, no test mode
    wreg(`OFS_CLRINT, 32'h0000_0008);
    hs_detected <= 1'b0;
    ev(5'h01);
    ev(5'h02);
    idle(2);
    chk(test_sel, 32'h0);
    rreg(`OFS_INTSTA);
    chk(v & 32'h0000_0009, 32'h0000_0008);
    $display("test full speed reset done");
    end_sim;
  end
endmodule // tb_top
